// >>> inc/swm_consts.svh
// Constants for the selective-wake mode control block
`ifndef SWM_CONSTS_SVH
`define SWM_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SWM_OFS_XCVR     8'h00
`define SWM_OFS_SBC      8'h04
`define SWM_OFS_STAT     8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SWM_MODE_LSB     0
`define SWM_MODE_MSB     2
`define SWM_B_CFGVAL     3
`define SWM_SBC_LSB      0
`define SWM_SBC_MSB      1
`define SWM_B_CFGERR     0
`define SWM_B_ARMED      1
`define SWM_B_SIL        2
`define SWM_B_BWAKE      3
`define SWM_B_WOKEN      4
`define SWM_EFF_LSB      5
`define SWM_EFF_MSB      9
`define SWM_CNT_LSB      10
`define SWM_CNT_MSB      15

// ----------------------------------------
// Transceiver mode codes
// ----------------------------------------
`define SWM_CODE_OFF0    3'h0
`define SWM_CODE_WK      3'h1
`define SWM_CODE_RXO     3'h2
`define SWM_CODE_NRM     3'h3
`define SWM_CODE_OFF1    3'h4
`define SWM_CODE_SWK     3'h5
`define SWM_CODE_RXS     3'h6
`define SWM_CODE_NRS     3'h7

// ----------------------------------------
// Counter limits, reset values and the AHB-Lite NONSEQ transfer code
// ----------------------------------------
`define SWM_CNT_MAX      6'h1F
`define SWM_CNT_OVF      6'h20
`define SWM_CNT_ZERO     6'h00
`define SWM_RST_MODE     3'h0
`define SWM_HTRANS_NSEQ  2'h2

`endif

// >>> inc/swm_pkg.sv
// Types shared by the selective-wake mode control block
package swm_pkg;

  // ----------------------------------------
  // Device and detection states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SBC_NORMAL  = 2'b00,
    SBC_STOP    = 2'b01,
    SBC_SLEEP   = 2'b10,
    SBC_RESTART = 2'b11
  } swm_sbc_type;

  typedef enum logic [2:0] {
    DET_OFF   = 3'b000,
    DET_WK    = 3'b001,
    DET_WUF   = 3'b010,
    DET_WUP1  = 3'b011,
    DET_WUP2  = 3'b100,
    DET_WOKEN = 3'b101
  } swm_det_type;

  // ----------------------------------------
  // Bundles
  // ----------------------------------------
  typedef struct packed {
    logic off;
    logic wakeCap;
    logic rxEn;
    logic txEn;
    logic selWake;
  } swm_eff_type;

  typedef struct packed {
    logic wakeFrame;
    logic wakePattern;
    logic errInc;
    logic errDec;
    logic silence;
    logic otherWake;
  } swm_evt_type;

endpackage

// >>> rtl/swm_ctrl.sv
// Selective-wake mode control with an AHB-Lite register slave
// ----------------------------------------
// ----------------------------------------
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "swm_consts.svh"
module swm_ctrl
  import swm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  swm_evt_type      busEvt,
  input  wire logic        busRxd,
  input  wire logic        hostTxd,
  output logic             rxdOut,
  output logic             txdBus,
  output logic             busWakeIrq,
  output logic             frameDetectEn,
  output swm_sbc_type      sbcMode,
  output swm_eff_type      effMode
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [2:0]   trcvMode;
  logic         cfgValid;
  logic         cfgErr;
  logic         armed;
  logic         silence;
  logic         busWake;
  logic         woken;
  logic         rearmSeen;
  logic [5:0]   errCnt;
  swm_det_type  detState;
  logic         wrPend;
  logic [7:0]   wrAddr;

  logic [2:0]   next_trcvMode;
  logic         next_cfgValid;
  logic         next_cfgErr;
  logic         next_armed;
  logic         next_silence;
  logic         next_busWake;
  logic         next_woken;
  logic         next_rearmSeen;
  logic [5:0]   next_errCnt;
  swm_det_type  next_detState;
  swm_sbc_type  next_sbcMode;
  logic         next_irq;
  logic         next_rxd;
  logic         next_txd;
  logic [31:0]  next_hrdata;

  logic         addrPhase;
  logic [2:0]   newMode;
  logic         wakeEvt;
  logic         cntEn;
  swm_det_type  detEvt;
  swm_eff_type  nextEff;

  function automatic logic swkCode(input logic [2:0] code);
    swkCode = code[2] & (|code[1:0]);
  endfunction

  // ----------------------------------------
  // Mode decoders
  // ----------------------------------------
  swm_mode_decode uDecCur (
    .modeField (trcvMode),
    .cfgErr    (cfgErr),
    .eff       (effMode)
  );

  swm_mode_decode uDecNext (
    .modeField (next_trcvMode),
    .cfgErr    (next_cfgErr),
    .eff       (nextEff)
  );

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Zero wait states; reads sample at the address phase
  assign addrPhase = hsel & hready & (htrans == `SWM_HTRANS_NSEQ | htrans[1]);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign newMode   = hwdata[`SWM_MODE_MSB:`SWM_MODE_LSB];

  always_comb begin
    next_hrdata = '0;
    if (addrPhase && !hwrite) begin
      unique case (haddr[7:0])
        `SWM_OFS_XCVR: next_hrdata[`SWM_B_CFGVAL:`SWM_MODE_LSB] = {cfgValid, trcvMode};
        `SWM_OFS_SBC: next_hrdata[`SWM_SBC_MSB:`SWM_SBC_LSB] = sbcMode;
        `SWM_OFS_STAT: begin
          next_hrdata[`SWM_B_CFGERR]              = cfgErr;
          next_hrdata[`SWM_B_ARMED]               = armed;
          next_hrdata[`SWM_B_SIL]                 = silence;
          next_hrdata[`SWM_B_BWAKE]               = busWake;
          next_hrdata[`SWM_B_WOKEN]               = woken;
          next_hrdata[`SWM_EFF_MSB:`SWM_EFF_LSB]  = effMode;
          next_hrdata[`SWM_CNT_MSB:`SWM_CNT_LSB]  = errCnt;
        end
        default: next_hrdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // Mode, flags and detection
  // ----------------------------------------
  always_comb begin
    next_trcvMode  = trcvMode;
    next_cfgValid  = cfgValid;
    next_cfgErr    = cfgErr;
    next_armed     = armed;
    next_silence   = silence;
    next_busWake   = busWake;
    next_woken     = woken;
    next_rearmSeen = rearmSeen;
    next_errCnt    = errCnt;
    next_sbcMode   = sbcMode;
    next_irq       = 1'b0;
    wakeEvt        = 1'b0;
    detEvt         = detState;
    cntEn          = (effMode.rxEn | (detState == DET_WUF)) & ~woken;

    // Software writes first so that hardware events below win
    if (wrPend && wrAddr == `SWM_OFS_XCVR) begin
      next_cfgValid = hwdata[`SWM_B_CFGVAL];
      if (sbcMode == SBC_NORMAL && newMode != trcvMode) begin
        next_trcvMode = newMode;
        if (woken && !rearmSeen) begin
          next_rearmSeen = 1'b1;
        end else if (rearmSeen && (newMode == `SWM_CODE_WK || swkCode(newMode))) begin
          next_woken     = 1'b0;
          next_rearmSeen = 1'b0;
        end
        if (swkCode(newMode) && !swkCode(trcvMode)) begin
          next_cfgErr = ~hwdata[`SWM_B_CFGVAL];
        end
      end else if (sbcMode == SBC_NORMAL && swkCode(trcvMode)
                   && !hwdata[`SWM_B_CFGVAL]) begin
        next_cfgErr = 1'b1;
      end
    end
    if (wrPend && wrAddr == `SWM_OFS_STAT) begin
      next_cfgErr  = cfgErr & ~hwdata[`SWM_B_CFGERR];
      next_busWake = busWake & ~hwdata[`SWM_B_BWAKE];
    end
    if (wrPend && wrAddr == `SWM_OFS_SBC) begin
      unique case (hwdata[`SWM_SBC_MSB:`SWM_SBC_LSB])
        SBC_NORMAL: begin
          if (sbcMode != SBC_SLEEP) begin
            next_sbcMode = SBC_NORMAL;
          end
        end
        SBC_STOP: begin
          if (sbcMode == SBC_NORMAL) begin
            next_sbcMode = SBC_STOP;
          end
        end
        SBC_SLEEP: begin
          if (sbcMode == SBC_NORMAL) begin
            next_sbcMode   = SBC_SLEEP;
            next_woken     = 1'b0;
            next_rearmSeen = 1'b0;
            if (swkCode(trcvMode)) begin
              next_trcvMode = `SWM_CODE_SWK;
            end else if (!trcvMode[2] && trcvMode != `SWM_CODE_OFF0) begin
              next_trcvMode = `SWM_CODE_WK;
            end
          end
        end
        default: next_sbcMode = sbcMode;
      endcase
    end

    // Bus events
    if (busEvt.errInc && cntEn) begin
      if (errCnt == `SWM_CNT_MAX) begin
        if (swkCode(trcvMode) && !cfgErr) begin
          next_errCnt = `SWM_CNT_OVF;
          next_cfgErr = 1'b1;
          wakeEvt     = 1'b1;
        end
      end else if (errCnt < `SWM_CNT_MAX) begin
        next_errCnt = errCnt + 6'h01;
      end
    end else if (busEvt.errDec && cntEn && errCnt != `SWM_CNT_ZERO) begin
      next_errCnt = errCnt - 6'h01;
    end
    if (busEvt.silence && (detState == DET_WUF || detState == DET_WUP2)) begin
      next_silence = 1'b1;
    end
    if (busEvt.silence && detState == DET_WUF) begin
      detEvt      = DET_WUP1;
      next_errCnt = `SWM_CNT_ZERO;
    end
    if (busEvt.wakePattern) begin
      next_silence = 1'b0;
      if (detState == DET_WUP1) begin
        detEvt = DET_WUF;
      end else if (detState == DET_WUP2 || detState == DET_WK) begin
        wakeEvt = 1'b1;
      end
    end
    if (busEvt.wakeFrame && detState == DET_WUF) begin
      wakeEvt = 1'b1;
    end

    // Consequences of a wake
    if (wakeEvt) begin
      next_woken   = 1'b1;
      next_busWake = 1'b1;
      next_armed   = 1'b0;
      next_irq     = (sbcMode != SBC_SLEEP);
    end
    if ((wakeEvt || busEvt.otherWake) && sbcMode == SBC_SLEEP) begin
      next_sbcMode  = SBC_RESTART;
      next_cfgValid = 1'b0;
    end
    if (next_cfgErr && !cfgErr && !wakeEvt && !woken) begin
      next_armed = 1'b1;
    end
    if (!next_trcvMode[2]) begin
      next_armed = 1'b0;
    end

    // Detection state follows the resulting mode
    if (next_woken) begin
      next_detState = DET_WOKEN;
    end else if (nextEff.off) begin
      next_detState = DET_OFF;
    end else if (!swkCode(next_trcvMode)) begin
      next_detState = DET_WK;
    end else if (!nextEff.selWake) begin
      next_detState = DET_WUP2;
    end else if (detEvt == DET_WUF || detEvt == DET_WUP1) begin
      next_detState = detEvt;
    end else begin
      next_detState = DET_WUF;
      next_armed    = 1'b1;
    end
    if ((next_detState == DET_WUF && detState != DET_WUF && detState != DET_WUP1)
        || (woken && !next_woken) || next_detState == DET_OFF || next_detState == DET_WK) begin
      next_errCnt = `SWM_CNT_ZERO;
    end
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  always_comb begin
    // Woken with receiver off signals the wake low
    next_rxd = effMode.rxEn ? busRxd : ~woken;
    next_txd = effMode.txEn ? hostTxd : 1'b1;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trcvMode      <= `SWM_RST_MODE;
      cfgValid      <= 1'b0;
      cfgErr        <= 1'b0;
      armed         <= 1'b0;
      silence       <= 1'b0;
      busWake       <= 1'b0;
      woken         <= 1'b0;
      rearmSeen     <= 1'b0;
      errCnt        <= `SWM_CNT_ZERO;
      detState      <= DET_OFF;
      sbcMode       <= SBC_NORMAL;
      wrPend        <= 1'b0;
      wrAddr        <= 8'h00;
      hrdata        <= 32'h0000_0000;
      busWakeIrq    <= 1'b0;
      rxdOut        <= 1'b1;
      txdBus        <= 1'b1;
      frameDetectEn <= 1'b0;
    end else begin
      trcvMode      <= next_trcvMode;
      cfgValid      <= next_cfgValid;
      cfgErr        <= next_cfgErr;
      armed         <= next_armed;
      silence       <= next_silence;
      busWake       <= next_busWake;
      woken         <= next_woken;
      rearmSeen     <= next_rearmSeen;
      errCnt        <= next_errCnt;
      detState      <= next_detState;
      sbcMode       <= next_sbcMode;
      wrPend        <= addrPhase & hwrite;
      wrAddr        <= haddr[7:0];
      hrdata        <= next_hrdata;
      busWakeIrq    <= next_irq;
      rxdOut        <= next_rxd;
      txdBus        <= next_txd;
      frameDetectEn <= (next_detState == DET_WUF);
    end
  end

endmodule

// >>> rtl/swm_mode_decode.sv
// Decoder from mode field and error flag to the actual transceiver mode
`timescale 1ns/1ps
`include "swm_consts.svh"
module swm_mode_decode
  import swm_pkg::*;
(
  input  wire logic [2:0]  modeField,
  input  wire logic        cfgErr,
  output swm_eff_type      eff
);

  logic swkSel;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign swkSel = modeField[2] & (|modeField[1:0]);

  always_comb begin
    eff         = '0;
    eff.selWake = swkSel & ~cfgErr;
    unique case (modeField)
      `SWM_CODE_OFF0, `SWM_CODE_OFF1: eff.off = 1'b1;
      `SWM_CODE_WK, `SWM_CODE_SWK:    eff.wakeCap = 1'b1;
      `SWM_CODE_RXO, `SWM_CODE_RXS:   eff.rxEn = 1'b1;
      `SWM_CODE_NRM, `SWM_CODE_NRS: begin
        eff.rxEn = 1'b1;
        eff.txEn = 1'b1;
      end
    endcase
  end

endmodule

// >>> tb/selective_wake_mode_control_tb.sv
// Self-checking testbench for the selective-wake mode control block
`timescale 1ns/1ps
`include "swm_consts.svh"
module selective_wake_mode_control_tb
  import swm_pkg::*;
;
  // ----------------------------------------
  // Signals and models
  // ----------------------------------------
  localparam logic [7:0] XC = `SWM_OFS_XCVR, SB = `SWM_OFS_SBC, ST = `SWM_OFS_STAT;
  localparam logic [31:0] EM = 32'h3E0;
  logic        clk = 0, sys_rst = 1, hsel = 1, hwrite = 0, hostTxd = 1, nodeDom = 0;
  logic        rdPend = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, e, m;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2, c;
  logic        hreadyout, hresp, busRxd, rxdOut, txdBus, busWakeIrq, frameDetectEn;
  wire         hready = hreadyout;
  swm_evt_type busEvt, evtReq = '0;
  swm_sbc_type sbcMode;
  swm_eff_type effMode;
  logic [31:0] expQ[$], mskQ[$];
  int          mismatches = 0, totalChecks = 0;
  swm_ctrl swm_ctrl_inst (.*);
  swm_bus_model swm_bus_model_inst (.*);
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    hostTxd <= 1'($urandom);
    nodeDom <= 1'($urandom);
  end
  // Read results are judged when the data phase closes
  always @(posedge clk) begin
    if (rdPend) begin
      e = expQ.pop_front();
      m = mskQ.pop_front();
      totalChecks++;
      if ((hrdata & m) !== e) begin
        $display("Error hrdata expected %h seen %h", e, hrdata & m);
        mismatches++;
      end
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, mk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= `SWM_HTRANS_NSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rdPend <= !w;
    if (!w) begin
      expQ.push_back(d & mk);
      mskQ.push_back(mk);
    end
    do @(posedge clk); while (hready !== 1'b1);
    rdPend <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, mk);
    bus(1'b0, a, d, mk);
  endtask
  task automatic ev(input swm_evt_type x);
    evtReq <= x;
    @(posedge clk);
    evtReq <= '0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] ef(input logic [2:0] k, input logic er);
    logic [4:0] v;
    case (k)
      3'h1: v = 5'h08;
      3'h2: v = 5'h04;
      3'h3: v = 5'h06;
      3'h5: v = 5'h09;
      3'h6: v = 5'h05;
      3'h7: v = 5'h07;
      default: v = 5'h10;
    endcase
    if (er) v[0] = 1'b0;
    return {22'h0, v, 5'h0};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(72));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(ST, 32'h200, 32'hFFFFFFFF);
    rd(XC, 32'h0, 32'hFFFFFFFF);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    repeat (8) begin
      c = 3'($urandom);
      wr(XC, {28'h1, c});
      rd(XC, {28'h1, c}, 32'hF);
      rd(ST, ef(c, 1'b0), EM | 32'h1);
    end
    wr(XC, 32'h9);
    wr(XC, 32'h5);
    rd(ST, 32'h101, EM | 32'h1);
    wr(ST, 32'h1);
    wr(XC, 32'h1);
    rd(ST, 32'h100, EM | 32'h1);
    wr(XC, 32'hE);
    wr(SB, 32'h1);
    wr(XC, 32'hB);
    rd(XC, 32'hE, 32'hF);
    rd(ST, ef(3'h6, 1'b0), EM | 32'h1);
    wr(SB, 32'h0);
    for (int i = 0; i < 8; i++) begin
      c = (i > 4) ? 3'h5 : (i == 2 || i == 3) ? 3'h1 : 3'(i);
      wr(XC, 32'h8 | i);
      wr(ST, 32'h9);
      wr(SB, 32'h2);
      rd(XC, {29'h0, c}, 32'h7);
      rd(ST, ef(c, 1'b0), EM | 32'h11);
      ev(6'h01);
      rd(SB, 32'h3, 32'h3);
      wr(SB, 32'h0);
    end
    wr(XC, 32'h9);
    wr(ST, 32'h9);
    wr(XC, 32'hD);
    wr(SB, 32'h2);
    rd(ST, 32'h122, EM | 32'h13);
    ev(6'h20);
    rd(SB, 32'h3, 32'h3);
    rd(XC, 32'h5, 32'hF);
    rd(ST, 32'h138, EM | 32'h1B);
    wr(SB, 32'h0);
    wr(XC, 32'hD);
    rd(ST, 32'h10, 32'h10);
    wr(ST, 32'h8);
    wr(XC, 32'hB);
    rd(ST, 32'h10, 32'h12);
    wr(XC, 32'hF);
    rd(ST, 32'h0, 32'h10);
    ev(6'h20);
    rd(ST, 32'h18, 32'h18);
    wr(XC, 32'hB);
    wr(XC, 32'hF);
    repeat (31) ev(6'h08);
    rd(ST, 32'h7C00, 32'hFC11);
    ev(6'h08);
    rd(ST, 32'h8011, 32'hFC11);
    wr(SB, 32'h2);
    rd(ST, 32'h101, EM | 32'h11);
    rd(XC, 32'h5, 32'h7);
    ev(6'h02);
    rd(ST, 32'hC, 32'h1C);
    wr(ST, 32'h8);
    ev(6'h10);
    rd(ST, 32'h18, 32'h1E);
    rd(SB, 32'h3, 32'h3);
    @(posedge clk);
    summarize();
  end
endmodule

// >>> tb/swm_bus_model.sv
// Bus network model: wired bus level and decoder event pulses
`timescale 1ns/1ps
module swm_bus_model
  import swm_pkg::*;
(
  input wire logic   clk,
  input wire logic   txdBus,
  input wire logic   nodeDom,
  input swm_evt_type evtReq,
  output swm_evt_type busEvt,
  output logic       busRxd
);
  // ----------------------------------------
  // Bus
  // ----------------------------------------
  // Recessive unless some node pulls it dominant
  assign busRxd = txdBus & ~nodeDom;
  // Events come as registered one-cycle pulses, like the frame decoder
  always_ff @(posedge clk) busEvt <= evtReq;
endmodule

// >>> tb/swm_ctrl_checker.sv
// Assertion checker for the selective-wake mode control block
`timescale 1ns/1ps
`include "swm_consts.svh"
module swm_ctrl_checker
  import swm_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input swm_evt_type      busEvt,
  input wire logic        busRxd,
  input wire logic        hostTxd,
  input wire logic        rxdOut,
  input wire logic        txdBus,
  input wire logic        busWakeIrq,
  input wire logic        frameDetectEn,
  input swm_sbc_type      sbcMode,
  input swm_eff_type      effMode
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic rdTake;
  assign rdTake = hsel && hready && htrans[1] && !hwrite;
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  stat_read_a: assert property (rdTake && haddr[7:0] == `SWM_OFS_STAT
    |=> hrdata[9:5] == $past(effMode)) else $error("status readback wrong");
  sbc_read_a: assert property (rdTake && haddr[7:0] == `SWM_OFS_SBC
    |=> hrdata[1:0] == $past(sbcMode)) else $error("state readback wrong");
  gap_read_a: assert property (rdTake && haddr[7:0] >= 8'h0C
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  off_decode_a: assert property (effMode.off |-> effMode[3:0] == 4'h0)
    else $error("off mode not quiet");
  tx_idle_a: assert property (!effMode.txEn && $past(!effMode.txEn) |-> txdBus)
    else $error("transmit while disabled");
  tx_pass_a: assert property (effMode.txEn && $past(effMode.txEn)
    |-> txdBus == $past(hostTxd)) else $error("transmit data lost");
  rx_pass_a: assert property (effMode.rxEn && $past(effMode.rxEn)
    |-> rxdOut == $past(busRxd)) else $error("receive data lost");
  irq_pulse_a: assert property (busWakeIrq |=> !busWakeIrq) else $error("wake pulse long");
  irq_cause_a: assert property ($rose(busWakeIrq) |-> $past(busEvt.wakeFrame)
    || $past(busEvt.wakePattern) || $past(busEvt.errInc)) else $error("wake no cause");
  irq_fire_a: assert property (busEvt.wakeFrame && frameDetectEn && sbcMode != SBC_SLEEP
    |=> busWakeIrq) else $error("frame wake without pulse");
  frame_gate_a: assert property (frameDetectEn |-> effMode.selWake)
    else $error("frame detect on");
  wake_c: cover property ($rose(busWakeIrq));
  frame_c: cover property (frameDetectEn);
  sleep_c: cover property (sbcMode == SBC_SLEEP);
endmodule
bind swm_ctrl swm_ctrl_checker swm_ctrl_checker_inst (.*);
